// File: common/addr_dec_pkg.sv
// Purpose: constants and carriers for the framer register address decoder
// Assumes: 8-bit host data bus, 12-bit host address, one 40 MHz clock
// Notes:   global register offsets and reset values live here only
package addr_dec_pkg;
	// ****************************************************************
	// address layout
	// ****************************************************************
	localparam int         ADDR_W        = 12;        // host address width
	localparam int         DATA_W        = 8;         // host data width
	localparam int         LOCAL_W       = 9;         // per-framer window bits
	localparam int         SEL_W         = 3;         // framer select bits
	localparam int         SEL_LSB       = 9;         // select field lsb
	localparam int         QUAD_SEL_W    = 2;         // quad part uses a[10:9]
	localparam logic [8:0] OFS_DEVICE_ID = 9'h000;    // global id register
	localparam logic [8:0] OFS_FRM_CTRL  = 9'h080;    // framer control
	localparam logic [8:0] OFS_IRQ_REQ   = 9'h081;    // master irq request
	localparam logic [8:0] OFS_IRQ_EN    = 9'h082;    // master irq enable
	localparam logic [8:0] OFS_TEST_CFG  = 9'h083;    // test configuration
	localparam logic [8:0] OFS_PRIM_CTRL = 9'h001;    // per-framer primary control
	localparam logic [7:0] RST_GLOBAL    = 8'h00;     // global register defaults
	localparam logic [7:0] RST_PRIM_CTRL = 8'h00;     // primary control default
	localparam int         GLB_RESET_BIT = 0;         // global soft reset bit in framer control
	localparam int         FRESET_BIT    = 7;         // per-framer soft reset bit in primary control
	localparam logic [7:0] ZERO_BYTE     = 8'h00;     // idle data value

	// ****************************************************************
	// carriers
	// ****************************************************************
	// one host bus cycle as seen on the pins
	typedef struct packed {
		logic              group_a_select_n; // first group select, low active
		logic              group_b_select_n; // second group select, low active
		logic              rd;               // read strobe, high active
		logic              wr;               // write strobe, high active
		logic [ADDR_W-1:0] addr;             // host address
		logic [DATA_W-1:0] wdata;            // write data
	} host_req_t;

	// decoded target of a bus cycle
	typedef struct packed {
		logic               hit;        // some select is low
		logic               group_b;    // second group chosen
		logic               is_global;  // address hits global space
		logic [SEL_W-1:0]   framer;     // framer within the group
		logic [LOCAL_W-1:0] local_ofs;  // offset inside the window
	} decode_t;
endpackage : addr_dec_pkg

// File: rtl/framer_register_address_decoder.sv
// Purpose: host port address decode for a multi-framer device
// Assumes: host pins synchronous to ref_clk_i, one cycle per access
// Notes:   read data is registered; the bus is driven only on a selected read
`timescale 1ns/100ps
module framer_register_address_decoder #(
	parameter int         NUM_SEL = 3,                   // 3 full decode, 2 quad part
	parameter logic [7:0] DEV_ID  = 8'h5A                // arbitrary identification value
) (
	input  wire logic                      ref_clk_i,      // system clock
	input  wire logic                      rst_i,          // hardware reset pin
	input  wire addr_dec_pkg::host_req_t   host_i,         // host bus cycle
	input  wire logic [15:0]               frm_irq_i,      // per-framer irq requests
	output logic [addr_dec_pkg::DATA_W-1:0] rdata_o,       // read data
	output logic                           rdata_oe_o,     // data bus drive enable
	output logic [15:0]                    frm_wr_o,       // per-framer write strobe
	output logic [15:0]                    frm_rd_o,       // per-framer read strobe
	output logic [addr_dec_pkg::LOCAL_W-1:0] frm_ofs_o,    // offset to the framers
	output logic [addr_dec_pkg::DATA_W-1:0] frm_wdata_o,   // data to the framers
	output logic [15:0]                    frm_reset_o     // per-framer soft reset
);
	import addr_dec_pkg::*;

	// ****************************************************************
	// decode
	// ****************************************************************
	decode_t                dec;           // current cycle's target
	logic [7:0]             ctrl_a, ctrl_b; // framer control per group
	logic [7:0]             req_a, req_b;  // irq request per group
	logic [7:0]             en_a, en_b;    // irq enable per group
	logic [7:0]             tst_a, tst_b;  // test config per group
	logic [15:0]            prim_reg;      // per-framer reset bits seen
	logic [3:0]             idx;           // flat framer index, group then framer

	always_comb begin
		dec.hit       = !host_i.group_a_select_n || !host_i.group_b_select_n;
		// b chosen when only b low
		dec.group_b   = host_i.group_a_select_n;
		dec.local_ofs = host_i.addr[LOCAL_W-1:0];
		if (NUM_SEL == QUAD_SEL_W)
			dec.framer = {1'b0, host_i.addr[SEL_LSB +: QUAD_SEL_W]};
		else
			dec.framer = host_i.addr[SEL_LSB +: SEL_W];
		dec.is_global = dec.local_ofs == OFS_DEVICE_ID || dec.local_ofs == OFS_FRM_CTRL
			|| dec.local_ofs == OFS_IRQ_REQ || dec.local_ofs == OFS_IRQ_EN
			|| dec.local_ofs == OFS_TEST_CFG;
		idx = {dec.group_b, dec.framer[SEL_W-1:0]};
	end

	// ****************************************************************
	// global banks, one per group
	// ****************************************************************
	global_reg_bank #(.NUM_FRM(8)) bank_a (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.wr_i      (dec.hit && !dec.group_b && host_i.wr && dec.is_global),
		.ofs_i     (dec.local_ofs),
		.wdata_i   (host_i.wdata),
		.frm_irq_i (frm_irq_i[7:0]),
		.frm_ctrl_o(ctrl_a),
		.irq_req_o (req_a),
		.irq_en_o  (en_a),
		.test_o    (tst_a)
	);
	global_reg_bank #(.NUM_FRM(8)) bank_b (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.wr_i      (dec.hit && dec.group_b && host_i.wr && dec.is_global),
		.ofs_i     (dec.local_ofs),
		.wdata_i   (host_i.wdata),
		.frm_irq_i (frm_irq_i[15:8]),
		.frm_ctrl_o(ctrl_b),
		.irq_req_o (req_b),
		.irq_en_o  (en_b),
		.test_o    (tst_b)
	);

	// ****************************************************************
	// framer strobes
	// ****************************************************************
	// one framer per local cycle
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			frm_wr_o    <= '0;
			frm_rd_o    <= '0;
			frm_ofs_o   <= '0;
			frm_wdata_o <= ZERO_BYTE;
		end else begin
			frm_wr_o    <= '0;
			frm_rd_o    <= '0;
			frm_ofs_o   <= dec.local_ofs;
			frm_wdata_o <= host_i.wdata;
			if (dec.hit && !dec.is_global) begin
				frm_wr_o[idx] <= host_i.wr;
				frm_rd_o[idx] <= host_i.rd;
			end
		end
	end

	// ****************************************************************
	// per-framer soft reset
	// ****************************************************************
	// hard, global and per-framer reset
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			prim_reg <= '0;
		end else begin
			prim_reg <= '0;
			if (dec.hit && host_i.wr && dec.local_ofs == OFS_PRIM_CTRL)
				prim_reg[idx] <= host_i.wdata[FRESET_BIT];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			frm_reset_o <= '1;
		else
			frm_reset_o <= prim_reg | {{8{ctrl_b[GLB_RESET_BIT]}}, {8{ctrl_a[GLB_RESET_BIT]}}};
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	// drive only on selected read
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_o    <= ZERO_BYTE;
			rdata_oe_o <= 1'b0;
		end else begin
			rdata_oe_o <= dec.hit && host_i.rd;
			rdata_o    <= ZERO_BYTE;
			if (dec.hit && host_i.rd && dec.is_global) begin
				unique case (dec.local_ofs)
					OFS_FRM_CTRL: rdata_o <= dec.group_b ? ctrl_b : ctrl_a;
					OFS_IRQ_REQ:  rdata_o <= dec.group_b ? req_b : req_a;
					OFS_IRQ_EN:   rdata_o <= dec.group_b ? en_b : en_a;
					OFS_TEST_CFG: rdata_o <= dec.group_b ? tst_b : tst_a;
					default:      rdata_o <= DEV_ID;
				endcase
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_idle_undriven;
		@(posedge ref_clk_i) disable iff (rst_i)
		!dec.hit |=> !rdata_oe_o && frm_wr_o == '0 && frm_rd_o == '0;
	endproperty
	a_idle_undriven: assert property (p_idle_undriven) else $error("bus driven without select");

	property p_global_no_strobe;
		@(posedge ref_clk_i) disable iff (rst_i)
		dec.hit && dec.is_global |=> frm_wr_o == '0 && frm_rd_o == '0;
	endproperty
	a_global_no_strobe: assert property (p_global_no_strobe) else $error("global access leaked to framer");

	// a pending global soft reset in the same group wins over the write
	property p_group_a_write;
		@(posedge ref_clk_i) disable iff (rst_i)
		!host_i.group_a_select_n && host_i.wr && dec.local_ofs == OFS_IRQ_EN && !ctrl_a[GLB_RESET_BIT]
		|=> en_a == $past(host_i.wdata);
	endproperty
	a_group_a_write: assert property (p_group_a_write) else $error("group a enable not written");

	property p_group_b_write;
		@(posedge ref_clk_i) disable iff (rst_i)
		host_i.group_a_select_n && !host_i.group_b_select_n && host_i.wr
		&& dec.local_ofs == OFS_TEST_CFG && !ctrl_b[GLB_RESET_BIT] |=> tst_b == $past(host_i.wdata);
	endproperty
	a_group_b_write: assert property (p_group_b_write) else $error("group b test not written");

	property p_framer_strobe;
		@(posedge ref_clk_i) disable iff (rst_i)
		dec.hit && !dec.is_global && host_i.rd |=> frm_rd_o[$past(idx)];
	endproperty
	a_framer_strobe: assert property (p_framer_strobe) else $error("framer read strobe missing");

	property p_hard_reset;
		@(posedge ref_clk_i) rst_i |=> ctrl_a == RST_GLOBAL && en_b == RST_GLOBAL && frm_reset_o == '1;
	endproperty
	a_hard_reset: assert property (p_hard_reset) else $error("defaults not restored");

	// group pulse for one cycle, then only per-framer requests remain
	property p_glb_reset_clears;
		@(posedge ref_clk_i) disable iff (rst_i)
		ctrl_a[GLB_RESET_BIT] |=> en_a == RST_GLOBAL && frm_reset_o[7:0] == 8'hFF
		##1 frm_reset_o[7:0] == $past(prim_reg[7:0]);
	endproperty
	a_glb_reset_clears: assert property (p_glb_reset_clears) else $error("global reset did not clear");
endmodule : framer_register_address_decoder

// File: rtl/global_reg_bank.sv
// Purpose: one group's global registers (framer control, irq enable, test)
// Assumes: writes qualified by the decoder, synchronous reset
// Notes:   irq request is read-only and built from the framer requests
`timescale 1ns/100ps
module global_reg_bank #(
	parameter int NUM_FRM = 8                             // framers in the group
) (
	input  wire logic                             ref_clk_i,  // system clock
	input  wire logic                             rst_i,      // hard reset
	input  wire logic                             wr_i,       // write strobe
	input  wire logic [addr_dec_pkg::LOCAL_W-1:0] ofs_i,      // window offset
	input  wire logic [addr_dec_pkg::DATA_W-1:0]  wdata_i,    // write data
	input  wire logic [NUM_FRM-1:0]               frm_irq_i,  // per-framer requests
	output logic      [addr_dec_pkg::DATA_W-1:0]  frm_ctrl_o, // framer control
	output logic      [addr_dec_pkg::DATA_W-1:0]  irq_req_o,  // master irq request
	output logic      [addr_dec_pkg::DATA_W-1:0]  irq_en_o,   // master irq enable
	output logic      [addr_dec_pkg::DATA_W-1:0]  test_o      // test configuration
);
	import addr_dec_pkg::*;

	// ****************************************************************
	// writable globals
	// ****************************************************************
	// both reset sources, hard and global soft
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || frm_ctrl_o[GLB_RESET_BIT]) begin
			frm_ctrl_o <= RST_GLOBAL;
			irq_en_o   <= RST_GLOBAL;
			test_o     <= RST_GLOBAL;
		end else if (wr_i) begin
			if (ofs_i == OFS_FRM_CTRL) frm_ctrl_o <= wdata_i;
			if (ofs_i == OFS_IRQ_EN)   irq_en_o   <= wdata_i;
			if (ofs_i == OFS_TEST_CFG) test_o     <= wdata_i;
		end
	end

	// ****************************************************************
	// read-only request register
	// ****************************************************************
	// masked framer requests
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || frm_ctrl_o[GLB_RESET_BIT]) begin
			irq_req_o <= RST_GLOBAL;
		end else begin
			irq_req_o <= DATA_W'(frm_irq_i) & irq_en_o;
		end
	end
endmodule : global_reg_bank

// File: sim/framer_register_address_decoder_tb.sv
// Purpose: self-checking bench for the host port address decoder
// Assumes: full decode part, sixteen framers in two groups
// Notes:   identification value below is arbitrary
`timescale 1ns/100ps
module framer_register_address_decoder_tb;
	import addr_dec_pkg::*;
	localparam logic [7:0] ID = 8'h3C; // arbitrary id value
	logic        ref_clk_i = 1'b0;     // clock
	logic        rst_i     = 1'b1;     // reset
	logic [15:0] frm_irq_i = 16'h0000; // framer requests
	host_req_t   host;                 // host pins
	logic [7:0]  rdata;                // read data
	logic        rdata_oe;             // bus drive
	logic [15:0] frm_wr;               // write strobes
	logic [15:0] frm_rd;               // read strobes
	logic [8:0]  frm_ofs;              // offset
	logic [7:0]  frm_wdata;            // data out
	logic [15:0] frm_reset;            // soft resets
	logic [15:0] q_frm_wr;             // quad part write strobes
	int          errors       = 0;     // mismatches
	int          total_checks = 0;     // compares
	int          cycles       = 0;     // timeout count
	always #12.5 ref_clk_i = ~ref_clk_i;
	host_model i_host_model (.ref_clk_i(ref_clk_i), .host_o(host));
	framer_register_address_decoder #(.NUM_SEL(3), .DEV_ID(ID)) i_framer_register_address_decoder (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .host_i(host), .frm_irq_i(frm_irq_i), .rdata_o(rdata),
		.rdata_oe_o(rdata_oe), .frm_wr_o(frm_wr), .frm_rd_o(frm_rd), .frm_ofs_o(frm_ofs),
		.frm_wdata_o(frm_wdata), .frm_reset_o(frm_reset));
	// quad decode on the same bus, top address bit ignored
	framer_register_address_decoder #(.NUM_SEL(2), .DEV_ID(ID)) i_framer_register_address_decoder_quad (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .host_i(host), .frm_irq_i(frm_irq_i), .rdata_o(),
		.rdata_oe_o(), .frm_wr_o(q_frm_wr), .frm_rd_o(), .frm_ofs_o(),
		.frm_wdata_o(), .frm_reset_o());
	// ****************************************************************
	// checking and closing
	// ****************************************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report
	// hang guard
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			final_report();
		end
	end
	// read one place and compare drive flag and data
	task automatic rd_chk(input logic g, input logic [11:0] a, input logic [7:0] exp);
		i_host_model.cyc(g, 1'b0, 1'b1, 1'b0, a, 8'h00);
		chk({7'h00, rdata_oe, rdata}, {8'h01, exp}, "read data");
	endtask : rd_chk
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset();
		@(posedge ref_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk(frm_reset, 16'hFFFF, "reset level");
		chk({7'h00, rdata_oe, rdata}, 16'h0000, "reset bus");
		@(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk(frm_reset, 16'h0000, "reset release");
	endtask : t_reset
	task automatic t_decode();
		for (int g = 0; g < 2; g++) begin
			for (int n = 0; n < 8; n++) begin
				i_host_model.cyc(g[0], 1'b0, 1'b0, 1'b1, {n[2:0], 9'h010}, 8'hA0 + n[7:0]);
				chk(frm_wr, 16'h0001 << (n + 8 * g), "write strobe");
				chk(q_frm_wr, 16'h0001 << (n % 4 + 8 * g), "quad write strobe");
				chk({7'h00, frm_ofs}, 16'h0010, "offset");
				chk({8'h00, frm_wdata}, {8'h00, 8'hA0 + n[7:0]}, "wdata");
				rd_chk(g[0], {n[2:0], 9'h1FF}, 8'h00);
				chk(frm_rd, 16'h0001 << (n + 8 * g), "read strobe");
			end
		end
	endtask : t_decode
	task automatic t_global();
		@(posedge ref_clk_i);
		frm_irq_i <= 16'hF0F0;
		for (int g = 0; g < 2; g++) begin
			i_host_model.cyc(g[0], 1'b0, 1'b0, 1'b1, {3'd5, OFS_IRQ_EN}, g ? 8'hC3 : 8'h3C);
			chk(frm_wr, 16'h0000, "global kept off framers");
			i_host_model.cyc(g[0], 1'b0, 1'b0, 1'b1, {3'd1, OFS_FRM_CTRL}, 8'h7E);
			i_host_model.cyc(g[0], 1'b0, 1'b0, 1'b1, {3'd7, OFS_TEST_CFG}, 8'h81);
			i_host_model.cyc(g[0], 1'b0, 1'b0, 1'b1, {3'd2, OFS_IRQ_REQ}, 8'hFF);
		end
		repeat (2) @(posedge ref_clk_i);
		for (int n = 0; n < 8; n++) begin
			rd_chk(1'b0, {n[2:0], OFS_IRQ_EN}, 8'h3C);
			rd_chk(1'b1, {n[2:0], OFS_IRQ_EN}, 8'hC3);
			rd_chk(n[0], {n[2:0], OFS_DEVICE_ID}, ID);
		end
		rd_chk(1'b0, {3'd3, OFS_IRQ_REQ}, 8'h30);
		rd_chk(1'b1, {3'd6, OFS_IRQ_REQ}, 8'hC0);
		rd_chk(1'b1, {3'd0, OFS_FRM_CTRL}, 8'h7E);
		rd_chk(1'b0, {3'd4, OFS_TEST_CFG}, 8'h81);
	endtask : t_global
	task automatic t_nosel();
		i_host_model.cyc(1'b0, 1'b1, 1'b1, 1'b1, {3'd2, OFS_IRQ_EN}, 8'hFF);
		chk(frm_wr | frm_rd, 16'h0000, "unselected strobes");
		chk({15'h0000, rdata_oe}, 16'h0000, "unselected drive");
		rd_chk(1'b0, {3'd2, OFS_IRQ_EN}, 8'h3C);
	endtask : t_nosel
	task automatic t_soft();
		i_host_model.cyc(1'b0, 1'b0, 1'b0, 1'b1, {3'd2, OFS_PRIM_CTRL}, 8'h80);
		chk(frm_wr, 16'h0004, "control write");
		@(posedge ref_clk_i);
		#1;
		chk(frm_reset, 16'h0004, "framer soft reset");
		i_host_model.cyc(1'b1, 1'b0, 1'b0, 1'b1, {3'd6, OFS_FRM_CTRL}, 8'h01);
		@(posedge ref_clk_i);
		#1;
		chk(frm_reset, 16'hFF00, "group soft reset pulse");
		repeat (2) @(posedge ref_clk_i);
		rd_chk(1'b1, {3'd0, OFS_IRQ_EN}, 8'h00);
		rd_chk(1'b1, {3'd1, OFS_FRM_CTRL}, 8'h00);
		rd_chk(1'b0, {3'd1, OFS_IRQ_EN}, 8'h3C);
		t_reset();
		rd_chk(1'b0, {3'd0, OFS_IRQ_EN}, 8'h00);
		rd_chk(1'b0, {3'd7, OFS_TEST_CFG}, 8'h00);
	endtask : t_soft
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		t_reset();
		t_decode();
		t_global();
		t_nosel();
		t_soft();
		final_report();
	end
endmodule : framer_register_address_decoder_tb

// File: sim/host_model.sv
// Purpose: host processor model, one byte access per call
// Assumes: decoder samples host pins on ref_clk_i rising edges
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/100ps
module host_model (
	input  wire logic               ref_clk_i, // system clock
	output addr_dec_pkg::host_req_t host_o     // host bus pins
);
	import addr_dec_pkg::*;
	// ****************************************************************
	// bus cycle
	// ****************************************************************
	// idle bus at time zero
	initial host_o = '{1'b1, 1'b1, 1'b0, 1'b0, 12'h000, 8'h00};
	task automatic cyc(input logic g, input logic none, input logic rd, input logic wr,
		input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		host_o <= '{g | none, ~g | none, rd, wr, a, d};
		@(posedge ref_clk_i);
		host_o <= '{1'b1, 1'b1, 1'b0, 1'b0, ~a, ~d};
		#1;
	endtask : cyc
endmodule : host_model
